// [shared/fpeia_pkg.sv]
// Package for the floating-point exception interrupt aggregator
`default_nettype none

package fpeia_pkg;

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  localparam int unsigned FPEIA_NUM_SRC = 6;
  localparam int unsigned FPEIA_BIT_INVALID_OP = 0;
  localparam int unsigned FPEIA_BIT_DIV_BY_ZERO = 1;
  localparam int unsigned FPEIA_BIT_UNDERFLOW = 2;
  localparam int unsigned FPEIA_BIT_OVERFLOW = 3;
  localparam int unsigned FPEIA_BIT_INEXACT = 4;
  localparam int unsigned FPEIA_BIT_INPUT_DENORMAL = 5;

  typedef logic [FPEIA_NUM_SRC-1:0] fpeia_src_t;

  localparam fpeia_src_t FPEIA_FLAG_RESET = 6'h00;
  localparam fpeia_src_t FPEIA_ENABLE_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int unsigned FPEIA_ADDR_W = 8;
  typedef logic [FPEIA_ADDR_W-1:0] fpeia_addr_t;

  localparam fpeia_addr_t FPEIA_OFS_RAW_STATUS = 8'h00;
  localparam fpeia_addr_t FPEIA_OFS_MASKED_STATUS = 8'h04;
  localparam fpeia_addr_t FPEIA_OFS_ENABLE = 8'h08;
  localparam fpeia_addr_t FPEIA_OFS_ENABLE_SET = 8'h0C;
  localparam fpeia_addr_t FPEIA_OFS_ENABLE_CLR = 8'h10;
  localparam fpeia_addr_t FPEIA_OFS_CTRL = 8'h14;
  localparam fpeia_addr_t FPEIA_OFS_VIEW = 8'h18;

  localparam int unsigned FPEIA_CTRL_VIEW_BIT = 0;
  localparam logic FPEIA_CTRL_RESET = 1'b0;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FPEIA_HTRANS_NONSEQ = 2'h2;
  localparam int unsigned FPEIA_HTRANS_ACTIVE_BIT = 1;
  localparam logic FPEIA_HRESP_OKAY = 1'b0;
  localparam logic [31:0] FPEIA_RDATA_ZERO = 32'h00000000;

endpackage : fpeia_pkg

`default_nettype wire

// [hdl/fpeia_top.sv]
// Floating-point exception interrupt aggregator with AHB-Lite registers
//
// Functional notes
// R1: Flags: underflow, overflow, div-zero, invalid, denormal, inexact.
// R2: All enabled flags are ORed into one interrupt request line.
// R3: A flag reaches the request only while its enable bit is set.
// R4: Enables set or cleared per source by bit mask, any combination at once.
// R5: Clear only flags named in the clear mask; cleared flags stop requesting.
// R6: Software can read raw flags and flags ANDed with enables.
// R7: Handler must clear pending flags or the request fires again.
// R8: Handler should clear early since a buffered write takes cycles.
// R9: Flags latch on an exception pulse, hold until cleared; all reset zero.
`timescale 1ns/10ps
`default_nettype none

module fpeia_top #(
  parameter int unsigned NUM_SRC = fpeia_pkg::FPEIA_NUM_SRC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Exception pulses from the floating-point unit, same clock
  input wire logic fp_invalid_op_i,
  input wire logic fp_div_by_zero_i,
  input wire logic fp_underflow_i,
  input wire logic fp_overflow_i,
  input wire logic fp_inexact_i,
  input wire logic fp_input_denormal_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Merged request to the system interrupt controller
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] fp_exc;

  always_comb begin
    fp_exc = '0;
    fp_exc[fpeia_pkg::FPEIA_BIT_INVALID_OP] = fp_invalid_op_i; // [R1]
    fp_exc[fpeia_pkg::FPEIA_BIT_DIV_BY_ZERO] = fp_div_by_zero_i; // [R1]
    fp_exc[fpeia_pkg::FPEIA_BIT_UNDERFLOW] = fp_underflow_i; // [R1]
    fp_exc[fpeia_pkg::FPEIA_BIT_OVERFLOW] = fp_overflow_i; // [R1]
    fp_exc[fpeia_pkg::FPEIA_BIT_INEXACT] = fp_inexact_i; // [R1]
    fp_exc[fpeia_pkg::FPEIA_BIT_INPUT_DENORMAL] = fp_input_denormal_i; // [R1]
  end

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  logic wr_pend;
  logic [fpeia_pkg::FPEIA_ADDR_W-1:0] wr_addr;
  logic addr_take;
  logic [fpeia_pkg::FPEIA_ADDR_W-1:0] addr_lo;

  assign addr_take = ce_i && hsel_i && hready_i &&
                     htrans_i[fpeia_pkg::FPEIA_HTRANS_ACTIVE_BIT];
  assign addr_lo = haddr_i[fpeia_pkg::FPEIA_ADDR_W-1:0];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (ce_i) begin
      wr_pend <= addr_take && hwrite_i;
      if (addr_take && hwrite_i) begin
        wr_addr <= addr_lo;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write strobes in the data phase
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] wmask;
  logic clr_stb;
  logic en_wr_stb;
  logic en_set_stb;
  logic en_clr_stb;
  logic ctrl_stb;

  function automatic logic hit(
    input logic [fpeia_pkg::FPEIA_ADDR_W-1:0] a,
    input logic [fpeia_pkg::FPEIA_ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction : hit

  assign wmask = hwdata_i[NUM_SRC-1:0];
  assign clr_stb = ce_i && wr_pend &&
                   hit(wr_addr, fpeia_pkg::FPEIA_OFS_RAW_STATUS);
  assign en_wr_stb = ce_i && wr_pend &&
                     hit(wr_addr, fpeia_pkg::FPEIA_OFS_ENABLE);
  assign en_set_stb = ce_i && wr_pend &&
                      hit(wr_addr, fpeia_pkg::FPEIA_OFS_ENABLE_SET);
  assign en_clr_stb = ce_i && wr_pend &&
                      hit(wr_addr, fpeia_pkg::FPEIA_OFS_ENABLE_CLR);
  assign ctrl_stb = ce_i && wr_pend &&
                    hit(wr_addr, fpeia_pkg::FPEIA_OFS_CTRL);

  // ----------------------------------------------------------------
  // Flags, enables and view select
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] flag;
  logic [NUM_SRC-1:0] enable;
  logic masked_view_select;
  logic [NUM_SRC-1:0] next_flag;
  logic [NUM_SRC-1:0] next_enable;
  logic [NUM_SRC-1:0] masked;

  always_comb begin
    next_flag = flag;
    if (clr_stb) begin
      next_flag = flag & ~wmask; // [R5]
    end
    // New event wins over a clear in the same cycle
    next_flag = next_flag | fp_exc; // [R9]
  end

  always_comb begin
    next_enable = enable;
    if (en_wr_stb) begin
      next_enable = wmask; // [R4]
    end else if (en_set_stb) begin
      next_enable = enable | wmask; // [R4]
    end else if (en_clr_stb) begin
      next_enable = enable & ~wmask; // [R4]
    end
  end

  assign masked = flag & enable; // [R6]

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag <= fpeia_pkg::FPEIA_FLAG_RESET; // [R9]
    end else if (ce_i) begin
      flag <= next_flag; // [R9]
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable <= fpeia_pkg::FPEIA_ENABLE_RESET; // [R9]
    end else if (ce_i) begin
      enable <= next_enable;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      masked_view_select <= fpeia_pkg::FPEIA_CTRL_RESET;
    end else if (ctrl_stb) begin
      masked_view_select <= hwdata_i[fpeia_pkg::FPEIA_CTRL_VIEW_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(next_flag & next_enable); // [R2] [R3]
    end
  end

  // ----------------------------------------------------------------
  // Read data and response
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = fpeia_pkg::FPEIA_RDATA_ZERO;
    unique case (addr_lo)
      fpeia_pkg::FPEIA_OFS_RAW_STATUS: begin
        next_rdata[NUM_SRC-1:0] = flag; // [R6]
      end
      fpeia_pkg::FPEIA_OFS_MASKED_STATUS: begin
        next_rdata[NUM_SRC-1:0] = masked; // [R6]
      end
      fpeia_pkg::FPEIA_OFS_ENABLE,
      fpeia_pkg::FPEIA_OFS_ENABLE_SET,
      fpeia_pkg::FPEIA_OFS_ENABLE_CLR: begin
        next_rdata[NUM_SRC-1:0] = enable;
      end
      fpeia_pkg::FPEIA_OFS_CTRL: begin
        next_rdata[fpeia_pkg::FPEIA_CTRL_VIEW_BIT] = masked_view_select;
      end
      fpeia_pkg::FPEIA_OFS_VIEW: begin
        next_rdata[NUM_SRC-1:0] = masked_view_select ? masked : flag; // [R6]
      end
      default: begin
        next_rdata = fpeia_pkg::FPEIA_RDATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= fpeia_pkg::FPEIA_RDATA_ZERO;
    end else if (ce_i) begin
      if (addr_take && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end else begin
        hrdata_o <= fpeia_pkg::FPEIA_RDATA_ZERO;
      end
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= fpeia_pkg::FPEIA_HRESP_OKAY;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= fpeia_pkg::FPEIA_HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_EVENT_LATCH: assert property ( // [R9]
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && (fp_exc != '0)) |=> ((flag & $past(fp_exc)) == $past(fp_exc)))
    else $error("Exception event not latched");

  AST_FLAG_HOLD: assert property ( // [R9]
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !clr_stb) |=> (flag == ($past(flag) | $past(fp_exc))))
    else $error("Flag changed without event or clear");

  AST_SELECTIVE_CLEAR: assert property ( // [R5]
    @(posedge mclk_i) disable iff (!rst_b_i)
    clr_stb |=> (flag == (($past(flag) & ~$past(wmask)) | $past(fp_exc))))
    else $error("Clear touched wrong flags");

  AST_IRQ_IS_OR: assert property ( // [R2]
    @(posedge mclk_i) disable iff (!rst_b_i)
    ##1 (irq_o == |(flag & enable)))
    else $error("Request differs from OR of enabled flags");

  AST_DISABLED_SILENT: assert property ( // [R3]
    @(posedge mclk_i) disable iff (!rst_b_i)
    (enable == '0) |-> !irq_o)
    else $error("Request with all sources disabled");

  AST_CLEAR_DROPS_IRQ: assert property ( // [R5]
    @(posedge mclk_i) disable iff (!rst_b_i)
    (clr_stb && (wmask == '1) && (fp_exc == '0)) |=> !irq_o)
    else $error("Request stays after clearing all flags");

  AST_ENABLE_SET: assert property ( // [R4]
    @(posedge mclk_i) disable iff (!rst_b_i)
    en_set_stb |=> (enable == ($past(enable) | $past(wmask))))
    else $error("Enable set mask not applied");

  AST_ENABLE_CLR: assert property ( // [R4]
    @(posedge mclk_i) disable iff (!rst_b_i)
    en_clr_stb |=> (enable == ($past(enable) & ~$past(wmask))))
    else $error("Enable clear mask not applied");

  AST_ENABLE_WRITE: assert property ( // [R4]
    @(posedge mclk_i) disable iff (!rst_b_i)
    en_wr_stb |=> (enable == $past(wmask)))
    else $error("Enable write mask not applied");

  AST_READ_VIEW: assert property ( // [R6]
    @(posedge mclk_i) disable iff (!rst_b_i)
    (addr_take && !hwrite_i &&
     (addr_lo == fpeia_pkg::FPEIA_OFS_VIEW))
    |=> (hrdata_o[NUM_SRC-1:0] ==
         ($past(masked_view_select) ? ($past(flag) & $past(enable))
                                    : $past(flag))))
    else $error("Selected status view read wrong");

  AST_READ_MASKED: assert property ( // [R6]
    @(posedge mclk_i) disable iff (!rst_b_i)
    (addr_take && !hwrite_i &&
     (addr_lo == fpeia_pkg::FPEIA_OFS_MASKED_STATUS))
    |=> (hrdata_o[NUM_SRC-1:0] == ($past(flag) & $past(enable))))
    else $error("Masked status read wrong");

  AST_READ_RAW: assert property ( // [R6]
    @(posedge mclk_i) disable iff (!rst_b_i)
    (addr_take && !hwrite_i &&
     (addr_lo == fpeia_pkg::FPEIA_OFS_RAW_STATUS))
    |=> (hrdata_o[NUM_SRC-1:0] == $past(flag)))
    else $error("Raw status read wrong");

  AST_FREEZE: assert property ( // [R9]
    @(posedge mclk_i) disable iff (!rst_b_i)
    !ce_i |=> ($stable(flag) && $stable(enable) && $stable(irq_o)))
    else $error("State moved while clock enable low");

endmodule : fpeia_top

`default_nettype wire

// [testbench/fpeia_fpu_model.sv]
// Behavioural floating-point unit driving the six exception events
`timescale 1ns/10ps
`default_nettype none

module fpeia_fpu_model (
  input wire logic mclk_i,
  output var logic [5:0] ev_o
);

  initial ev_o = 6'h00;

  // One-cycle exception pulse per selected source
  task automatic raise(input logic [5:0] m);
    @(posedge mclk_i);
    ev_o <= m;
    @(posedge mclk_i);
    ev_o <= 6'h00;
  endtask : raise

endmodule : fpeia_fpu_model
`default_nettype wire

// [testbench/fpeia_top_tb.sv]
// Self-checking testbench for the exception interrupt aggregator
`timescale 1ns/10ps
`default_nettype none

module fpeia_top_tb;
  localparam fpeia_pkg::fpeia_addr_t RAW = fpeia_pkg::FPEIA_OFS_RAW_STATUS;
  localparam fpeia_pkg::fpeia_addr_t MSK = fpeia_pkg::FPEIA_OFS_MASKED_STATUS;
  localparam fpeia_pkg::fpeia_addr_t ENA = fpeia_pkg::FPEIA_OFS_ENABLE;
  localparam fpeia_pkg::fpeia_addr_t SET = fpeia_pkg::FPEIA_OFS_ENABLE_SET;
  localparam fpeia_pkg::fpeia_addr_t CLR = fpeia_pkg::FPEIA_OFS_ENABLE_CLR;
  localparam fpeia_pkg::fpeia_addr_t CTL = fpeia_pkg::FPEIA_OFS_CTRL;
  localparam fpeia_pkg::fpeia_addr_t VUE = fpeia_pkg::FPEIA_OFS_VIEW;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic hresp_o;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h00000000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h00000000;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic irq_o;
  logic [5:0] ev;
  logic [31:0] exp;
  int bad_count = 0;
  int n_checks = 0;

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  fpeia_fpu_model fpeia_fpu_model_inst (.mclk_i(mclk_i), .ev_o(ev));

  fpeia_top fpeia_top_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .fp_invalid_op_i(ev[0]), .fp_div_by_zero_i(ev[1]),
    .fp_underflow_i(ev[2]), .fp_overflow_i(ev[3]),
    .fp_inexact_i(ev[4]), .fp_input_denormal_i(ev[5]),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .irq_o(irq_o)
  );

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Single AHB-Lite word transfer, waits on hready in both phases
  task automatic bus(input logic w, input fpeia_pkg::fpeia_addr_t a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h000000, a};
    htrans_i <= fpeia_pkg::FPEIA_HTRANS_NONSEQ;
    hwrite_i <= w;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
    chk("hresp", 32'h00000000, {31'h00000000, hresp_o});
  endtask : bus

  task automatic wr(input fpeia_pkg::fpeia_addr_t a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input fpeia_pkg::fpeia_addr_t a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk($sformatf("reg %h", a), e, r);
  endtask : rd

  task automatic irq(input logic e);
    @(negedge mclk_i);
    chk("irq", {31'h00000000, e}, {31'h00000000, irq_o});
  endtask : irq

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(RAW, 32'h00000000);
    rd(ENA, 32'h00000000);
    rd(CTL, 32'h00000000);
    irq(1'b0);
    $display("test reset done");
    exp = 32'h00000000;
    for (int i = 0; i < 6; i++) begin
      fpeia_fpu_model_inst.raise(6'h01 << i);
      exp = exp | (32'h00000001 << i);
      rd(RAW, exp);
      rd(MSK, 32'h00000000);
      irq(1'b0);
    end
    $display("test sources done");
    wr(SET, 32'h00000009);
    wr(SET, 32'h00000024);
    rd(ENA, 32'h0000002D);
    wr(CLR, 32'h00000021);
    rd(SET, 32'h0000000C);
    rd(MSK, 32'h0000000C);
    irq(1'b1);
    wr(CTL, 32'h00000001);
    rd(CTL, 32'h00000001);
    rd(VUE, 32'h0000000C);
    wr(CTL, 32'h00000000);
    rd(VUE, 32'h0000003F);
    $display("test enables done");
    wr(RAW, 32'h00000008);
    rd(RAW, 32'h00000037);
    irq(1'b1);
    wr(RAW, 32'h00000004);
    irq(1'b0);
    rd(MSK, 32'h00000000);
    wr(ENA, 32'h00000030);
    irq(1'b1);
    wr(RAW, 32'h0000003F);
    irq(1'b0);
    rd(RAW, 32'h00000000);
    $display("test clear done");
    wr(8'h40, 32'h0000003F);
    rd(8'h40, 32'h00000000);
    wr(MSK, 32'h0000003F);
    rd(ENA, 32'h00000030);
    $display("test unmapped done");
    @(posedge mclk_i);
    ce_i <= 1'b0;
    fpeia_fpu_model_inst.raise(6'h3F);
    ce_i <= 1'b1;
    rd(RAW, 32'h00000000);
    irq(1'b0);
    $display("test freeze done");
    fpeia_fpu_model_inst.raise(6'h3F);
    wr(ENA, 32'h0000003F);
    irq(1'b1);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    irq(1'b0);
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(RAW, 32'h00000000);
    rd(ENA, 32'h00000000);
    $display("test mid-run reset done");
    wrap_up();
  end

endmodule : fpeia_top_tb
`default_nettype wire
